// ### dv/bus_talker.sv
`timescale 1ns/10ps

module bus_talker (
  input wire logic ref_clk,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_char,
  output logic in_end
);
  logic rdy_q;

  initial begin
    in_valid = 1'b0;
    in_char = 8'h00;
    in_end = 1'b0;
  end

  // Ready as it stands before the coming edge
  always @(negedge ref_clk) rdy_q = in_ready;

  // Sends one program message; colons and separators come with the text
  task automatic send(input string s, input bit use_end, input int gap);
    string m;
    m = s;
    if (!use_end && m[m.len()-1] != 8'h0A && m[m.len()-1] != 8'h0D) begin
      m = {m, "\n"};
    end
    for (int i = 0; i < m.len(); i++) begin
      in_valid <= 1'b1;
      in_char <= m[i];
      in_end <= use_end && (i == m.len() - 1);
      do @(posedge ref_clk); while (rdy_q !== 1'b1);
      if (gap > 0 || i == m.len() - 1) begin
        in_valid <= 1'b0;
        in_end <= 1'b0;
        // Released line must not keep showing the last character
        in_char <= ~m[i];
        repeat (gap) @(posedge ref_clk);
      end
    end
  endtask
endmodule

// ### dv/test_scpi_message_parser.sv
`timescale 1ns/10ps
`include "scpi_cfg.svh"

module test_scpi_message_parser;
  localparam int DM = 16;
  typedef struct packed {
    logic [`NODE_W-1:0] node;
    logic q;
    logic c;
    logic [$clog2(DM+1)-1:0] len;
    logic [31:0] word;
    logic [31:0] data;
  } rec_type;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic in_valid;
  logic in_end;
  logic in_ready;
  logic unit_valid;
  logic unit_query;
  logic unit_common;
  logic syntax_err;
  logic msg_done;
  logic [7:0] in_char;
  logic [`NODE_W-1:0] unit_node;
  logic [`KW_BITS-1:0] unit_word;
  logic [DM*8-1:0] unit_data;
  logic [$clog2(DM+1)-1:0] unit_data_len;
  int fails = 0;
  int compares = 0;
  int errs = 0;
  int dones = 0;
  int busy = 0;
  rec_type units[$];

  always #4 ref_clk = ~ref_clk;

  scpi_message_parser #(.DATA_MAX(DM)) uut (
    .ref_clk(ref_clk), .rst(rst), .in_valid(in_valid), .in_char(in_char),
    .in_end(in_end), .in_ready(in_ready), .unit_valid(unit_valid),
    .unit_node(unit_node), .unit_query(unit_query),
    .unit_common(unit_common), .unit_word(unit_word),
    .unit_data(unit_data), .unit_data_len(unit_data_len),
    .syntax_err(syntax_err), .msg_done(msg_done)
  );

  bus_talker talker (
    .ref_clk(ref_clk), .in_ready(in_ready), .in_valid(in_valid),
    .in_char(in_char), .in_end(in_end)
  );

  // Pulses last one cycle, so every cycle is looked at once settled
  always @(posedge ref_clk) begin
    #1;
    if (unit_valid === 1'b1) begin
      units.push_back('{unit_node, unit_query, unit_common, unit_data_len,
                        unit_word[31:0], unit_data[31:0]});
    end
    if (syntax_err === 1'b1) errs++;
    if (msg_done === 1'b1) dones++;
    if (in_ready !== 1'b1) busy++;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic run(input string s, input bit e, input int gap,
                     input int nu, input int ne);
    int n;
    int exp_busy;
    units.delete();
    errs = 0;
    dones = 0;
    busy = 0;
    // Only a bus end on a plain character holds off the next one
    exp_busy = (e && s[s.len()-1] != 8'h0A && s[s.len()-1] != 8'h0D);
    talker.send(s, e, gap);
    n = 0;
    while (dones == 0 && n < 30) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (3) @(posedge ref_clk);
    chk("msg_done count", 1, dones);
    chk("unit count", nu, units.size());
    chk("syntax_err count", ne, errs);
    chk("in_ready low cycles", exp_busy, busy);
  endtask

  task automatic unit_is(input int i, input int node, input bit q,
                         input bit c, input int len, input logic [31:0] d);
    if (units.size() > i) begin
      chk("unit_node", node, units[i].node);
      chk("unit_query", q, units[i].q);
      chk("unit_common", c, units[i].c);
      chk("unit_data_len", len, units[i].len);
      chk("unit_data", d, units[i].data);
    end
  endtask

  task automatic t_forms;
    run("VOLT 5\n", 0, 0, 1, 0);
    unit_is(0, 7, 0, 0, 1, 32'h35);
    run("voltage 5\n", 0, 2, 1, 0);
    unit_is(0, 7, 0, 0, 1, 32'h35);
    if (units.size() > 0) chk("unit_word", 32'h54414745, units[0].word);
    run("SOURce:VOLTage 5\n", 0, 0, 1, 0);
    unit_is(0, 7, 0, 0, 1, 32'h35);
    run("vOlT:lEv:TrIg 14\r", 0, 0, 1, 0);
    unit_is(0, 12, 0, 0, 2, 32'h3134);
    $display("test forms done");
  endtask

  task automatic t_bad;
    run("VOLTA 5\n", 0, 0, 0, 1);
    run("INIT:IMME\n", 0, 0, 0, 1);
    run("VOLT  5\n", 0, 0, 0, 1);
    $display("test bad forms done");
  endtask

  task automatic t_tree;
    run("STAT:OPER:COND?;ENAB 16\n", 0, 0, 2, 0);
    unit_is(0, 28, 1, 0, 0, 32'h0);
    unit_is(1, 29, 0, 0, 2, 32'h3136);
    run("meas:volt?;curr?\n", 0, 0, 2, 0);
    unit_is(1, 22, 1, 0, 0, 32'h0);
    run("MEAS:VOLT?;:CURR?\n", 0, 0, 2, 0);
    unit_is(1, 8, 1, 0, 0, 32'h0);
    run("SOUR:VOLT? MAX\n", 0, 0, 1, 0);
    unit_is(0, 7, 1, 0, 3, 32'h4D4158);
    $display("test tree done");
  endtask

  task automatic t_root;
    string names[6];
    string pre;
    names = '{"INIT", "MEAS", "OUTP", "SOUR", "STAT", "SYST"};
    for (int i = 0; i < 6; i++) begin
      pre = (i % 2 == 1) ? ":" : "";
      run({pre, names[i], "\n"}, 0, 0, 1, 0);
      unit_is(0, i + 1, 0, 0, 0, 32'h0);
    end
    run("FUNC:MODE\n", 0, 0, 1, 0);
    unit_is(0, 36, 0, 0, 0, 32'h0);
    $display("test root done");
  endtask

  task automatic t_terms;
    string terms[3];
    terms = '{"\n", "\r", "\r\n"};
    for (int i = 0; i < 3; i++) begin
      run({"INIT", terms[i]}, 0, 0, 1, 0);
      unit_is(0, 1, 0, 0, 0, 32'h0);
    end
    run("STAT:OPER?\n", 0, 0, 1, 0);
    run("PRES\n", 0, 0, 0, 1);
    run("OUTP ON", 1, 0, 1, 0);
    unit_is(0, 3, 0, 0, 2, 32'h4F4E);
    $display("test terminators done");
  endtask

  task automatic t_common;
    run("*IDN?;X\n", 0, 0, 1, 1);
    unit_is(0, 0, 1, 1, 0, 32'h0);
    $display("test common done");
  endtask

  task automatic t_edges;
    run("INIT:CONT;IMM\n", 0, 0, 2, 0);
    unit_is(0, 21, 0, 0, 0, 32'h0);
    unit_is(1, 20, 0, 0, 0, 32'h0);
    run("STAT:OPRX:COND?\n", 0, 0, 0, 1);
    run("INIT:FOO;INIT\n", 0, 0, 1, 1);
    unit_is(0, 1, 0, 0, 0, 32'h0);
    run("INIT;;INIT\n", 0, 0, 2, 1);
    run("\n", 0, 0, 0, 0);
    run("INIT\n", 1, 0, 1, 0);
    run("STAT:QUESTIONABLE?\n", 0, 0, 1, 0);
    unit_is(0, 26, 1, 0, 0, 32'h0);
    run("STAT:QUESTIONABLEX\n", 0, 0, 0, 1);
    run("OUTP 1234567890123456\n", 0, 0, 1, 0);
    unit_is(0, 3, 0, 0, 16, 32'h33343536);
    run("OUTP 12345678901234567\n", 0, 0, 0, 1);
    $display("test edge cases done");
  endtask

  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_forms();
    t_bad();
    t_tree();
    t_root();
    t_terms();
    t_common();
    t_edges();
    complete_run();
  end

  // Whole run needs well under two thousand cycles
  initial begin
    repeat (6000) @(posedge ref_clk);
    fails++;
    complete_run();
  end
endmodule

// ### verilog/keyword_matcher.sv
`timescale 1ns/10ps
`include "scpi_cfg.svh"

module keyword_matcher (
  input wire logic [`KW_BITS-1:0] word,
  input wire logic [3:0] word_len,
  input wire logic [`NODE_W-1:0] level,
  output logic hit,
  output logic [`NODE_W-1:0] hit_node,
  output logic [`NODE_W-1:0] hit_parent
);

  localparam scpi_pkg::kw_entry_type TREE [`NODE_COUNT] = '{
    '{96'h0, 4'h0, 4'h0, 6'h00, 1'b0},
    '{96'("INITIATE"), 4'h8, 4'h4, 6'h00, 1'b0},
    '{96'("MEASURE"), 4'h7, 4'h4, 6'h00, 1'b0},
    '{96'("OUTPUT"), 4'h6, 4'h4, 6'h00, 1'b0},
    '{96'("SOURCE"), 4'h6, 4'h4, 6'h00, 1'b1},
    '{96'("STATUS"), 4'h6, 4'h4, 6'h00, 1'b0},
    '{96'("SYSTEM"), 4'h6, 4'h4, 6'h00, 1'b0},
    '{96'("VOLTAGE"), 4'h7, 4'h4, 6'h04, 1'b0},
    '{96'("CURRENT"), 4'h7, 4'h4, 6'h04, 1'b0},
    '{96'("FUNCTION"), 4'h8, 4'h4, 6'h04, 1'b0},
    '{96'("LEVEL"), 4'h5, 4'h3, 6'h07, 1'b1},
    '{96'("IMMEDIATE"), 4'h9, 4'h3, 6'h0A, 1'b1},
    '{96'("TRIGGERED"), 4'h9, 4'h4, 6'h0A, 1'b0},
    '{96'("MODE"), 4'h4, 4'h4, 6'h07, 1'b0},
    '{96'("RANGE"), 4'h5, 4'h4, 6'h07, 1'b0},
    '{96'("LEVEL"), 4'h5, 4'h3, 6'h08, 1'b1},
    '{96'("IMMEDIATE"), 4'h9, 4'h3, 6'h0F, 1'b1},
    '{96'("TRIGGERED"), 4'h9, 4'h4, 6'h0F, 1'b0},
    '{96'("MODE"), 4'h4, 4'h4, 6'h08, 1'b0},
    '{96'("RANGE"), 4'h5, 4'h4, 6'h08, 1'b0},
    '{96'("IMMEDIATE"), 4'h9, 4'h3, 6'h01, 1'b1},
    '{96'("CONTINUOUS"), 4'hA, 4'h4, 6'h01, 1'b0},
    '{96'("CURRENT"), 4'h7, 4'h4, 6'h02, 1'b0},
    '{96'("VOLTAGE"), 4'h7, 4'h4, 6'h02, 1'b0},
    '{96'("STATE"), 4'h5, 4'h4, 6'h03, 1'b1},
    '{96'("OPERATION"), 4'h9, 4'h4, 6'h05, 1'b0},
    '{96'("QUESTIONABLE"), 4'hC, 4'h4, 6'h05, 1'b0},
    '{96'("PRESET"), 4'h6, 4'h4, 6'h05, 1'b0},
    '{96'("CONDITION"), 4'h9, 4'h4, 6'h19, 1'b0},
    '{96'("ENABLE"), 4'h6, 4'h4, 6'h19, 1'b0},
    '{96'("EVENT"), 4'h5, 4'h4, 6'h19, 1'b1},
    '{96'("CONDITION"), 4'h9, 4'h4, 6'h1A, 1'b0},
    '{96'("ENABLE"), 4'h6, 4'h4, 6'h1A, 1'b0},
    '{96'("EVENT"), 4'h5, 4'h4, 6'h1A, 1'b1},
    '{96'("ERROR"), 4'h5, 4'h3, 6'h06, 1'b0},
    '{96'("VERSION"), 4'h7, 4'h4, 6'h06, 1'b0},
    '{96'("MODE"), 4'h4, 4'h4, 6'h09, 1'b0}
  };

  logic [`NODE_COUNT-1:0] match;

  assign match[0] = 1'b0;

  generate
    for (genvar i = 1; i < `NODE_COUNT; i++) begin : g_entry
      logic [6:0] shift;
      logic parent_ok;
      logic spell_ok;
      assign shift = {TREE[i].len - TREE[i].slen, 3'h0};
      // An optional parent lets the child be reached from one level up
      assign parent_ok = (TREE[i].parent == level) ||
        (TREE[TREE[i].parent].opt &&
         TREE[TREE[i].parent].parent == level);
      // Exactly the long or exactly the short spelling, nothing between
      assign spell_ok =
        (word_len == TREE[i].len && word == TREE[i].name) ||
        (word_len == TREE[i].slen &&
         word == (TREE[i].name >> shift));
      assign match[i] = parent_ok && spell_ok;
    end
  endgenerate

  // Lowest entry wins when a spelling is reachable twice
  always_comb begin
    hit = 1'b0;
    hit_node = `ROOT_NODE;
    hit_parent = `ROOT_NODE;
    for (int i = `NODE_COUNT - 1; i > 0; i--) begin
      if (match[i]) begin
        hit = 1'b1;
        hit_node = `NODE_W'(i);
        hit_parent = TREE[i].parent;
      end
    end
  end

endmodule

// ### verilog/scpi_cfg.svh
`ifndef SCPI_CFG_SVH
`define SCPI_CFG_SVH

// Characters with a role in the message grammar
`define CHAR_LF 8'h0A
`define CHAR_CR 8'h0D
`define CHAR_SPACE 8'h20
`define CHAR_STAR 8'h2A
`define CHAR_COLON 8'h3A
`define CHAR_SEMI 8'h3B
`define CHAR_QUERY 8'h3F
`define CHAR_DIG_LO 8'h30
`define CHAR_DIG_HI 8'h39
`define CHAR_UP_LO 8'h41
`define CHAR_UP_HI 8'h5A
`define CHAR_LOW_LO 8'h61
`define CHAR_LOW_HI 8'h7A
`define CASE_BIT 8'h20

// Keyword buffer and command tree
`define KW_CHARS 12
`define KW_BITS 96
`define NODE_W 6
`define NODE_COUNT 37
`define ROOT_NODE 6'h00
`define DATA_MAX_DEF 16

`endif

// ### verilog/scpi_message_parser.sv
`timescale 1ns/10ps
`include "scpi_cfg.svh"

// Notes on behaviour
// - A keyword is accepted in short or long form as one command.
// - Any other spelling, such as a cut long form, is a syntax error.
// - Keyword letters are matched without regard to case.
// - A separating colon moves the tree position below the keyword.
// - A question mark after the last keyword makes the unit a query.
// - One space then a parameter follows the last keyword or query mark.
// - Semicolons split units; each unit is delivered in turn.
// - A colon before a unit's first keyword resets the position to root.
// - LF, CR, or CR then LF each end a message.
// - A terminator returns the tree position to the root.
// - Optional keywords may be left out before a later keyword; leaving out the last one yields its parent's node.
// - Voltage, current and function branches are also reachable at root.
// - Root holds initiate, measure, output, source, status and system.
// - A unit without leading colon resolves beside the previous unit.
// - The first unit of a message always starts at the root.
// - A keyword starting with an asterisk is a common command.

module scpi_message_parser #(
  parameter int DATA_MAX = `DATA_MAX_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [7:0] in_char,
  input wire logic in_end,
  output logic in_ready,
  output logic unit_valid,
  output logic [`NODE_W-1:0] unit_node,
  output logic unit_query,
  output logic unit_common,
  output logic [`KW_BITS-1:0] unit_word,
  output logic [DATA_MAX*8-1:0] unit_data,
  output logic [$clog2(DATA_MAX+1)-1:0] unit_data_len,
  output logic syntax_err,
  output logic msg_done
);

  localparam int DLW = $clog2(DATA_MAX + 1);

  generate
    if (DATA_MAX < 2 || DATA_MAX > 255) begin : g_bad_data_max
      $error("DATA_MAX must lie between 2 and 255");
    end
  endgenerate

  typedef struct packed {
    scpi_pkg::parse_state_type st;
    logic [`NODE_W-1:0] cur_node;
    logic [`NODE_W-1:0] unit_base;
    logic [`NODE_W-1:0] last_node;
    logic [`NODE_W-1:0] last_parent;
    logic [`KW_BITS-1:0] kw;
    logic [3:0] kw_len;
    logic common;
    logic query;
    logic cr_seen;
    logic end_pend;
    logic [DATA_MAX*8-1:0] dat;
    logic [DLW-1:0] dat_len;
    logic in_ready_r;
    logic unit_valid_r;
    logic [`NODE_W-1:0] unit_node_r;
    logic unit_query_r;
    logic unit_common_r;
    logic [`KW_BITS-1:0] unit_word_r;
    logic [DATA_MAX*8-1:0] unit_data_r;
    logic [DLW-1:0] unit_data_len_r;
    logic syntax_err_r;
    logic msg_done_r;
  } parse_type;

  parse_type s_r;
  parse_type s_nxt;

  logic take;
  logic [7:0] ch;
  logic is_term_chr;
  logic kw_chr;
  logic hit;
  logic [`NODE_W-1:0] hit_node;
  logic [`NODE_W-1:0] hit_parent;

  assign take = in_valid && s_r.in_ready_r;
  assign is_term_chr = (in_char == `CHAR_LF) || (in_char == `CHAR_CR);
  // Fold lower case before it reaches the keyword buffer
  assign ch = (in_char >= `CHAR_LOW_LO && in_char <= `CHAR_LOW_HI) ?
    (in_char & ~`CASE_BIT) : in_char;
  assign kw_chr = (ch >= `CHAR_UP_LO && ch <= `CHAR_UP_HI) ||
    (ch >= `CHAR_DIG_LO && ch <= `CHAR_DIG_HI);

  keyword_matcher u_matcher (
    .word(s_r.kw),
    .word_len(s_r.kw_len),
    .level(s_r.cur_node),
    .hit(hit),
    .hit_node(hit_node),
    .hit_parent(hit_parent)
  );

  always_comb begin
    logic close_unit;
    logic term;
    logic err;
    logic unit_ok;
    logic [`NODE_W-1:0] next_level;
    close_unit = 1'b0;
    term = 1'b0;
    err = 1'b0;
    unit_ok = 1'b0;
    next_level = s_r.unit_base;
    s_nxt = s_r;
    s_nxt.unit_valid_r = 1'b0;
    s_nxt.syntax_err_r = 1'b0;
    s_nxt.msg_done_r = 1'b0;
    s_nxt.in_ready_r = 1'b1;
    if (s_r.end_pend) begin
      // Bus end came with the last byte; close the message now
      s_nxt.end_pend = 1'b0;
      s_nxt.cr_seen = 1'b0;
      close_unit = 1'b1;
      term = 1'b1;
    end else if (take) begin
      s_nxt.cr_seen = (in_char == `CHAR_CR);
      s_nxt.end_pend = in_end && !is_term_chr;
      s_nxt.in_ready_r = !(in_end && !is_term_chr);
      if (s_r.cr_seen && in_char == `CHAR_LF) begin
        // Tail of a CR LF pair, already acted on
        s_nxt.cr_seen = 1'b0;
      end else if (is_term_chr) begin
        close_unit = 1'b1;
        term = 1'b1;
      end else if (in_char == `CHAR_SEMI && s_r.st != scpi_pkg::ST_DATA) begin
        close_unit = 1'b1;
      end else if (in_char == `CHAR_SEMI) begin
        close_unit = 1'b1;
      end else begin
        case (s_r.st)
          scpi_pkg::ST_START: begin
            if (ch == `CHAR_COLON) begin
              s_nxt.cur_node = `ROOT_NODE;
              s_nxt.st = scpi_pkg::ST_KEY;
            end else if (ch == `CHAR_STAR) begin
              s_nxt.common = 1'b1;
              s_nxt.kw = {s_r.kw[`KW_BITS-9:0], ch};
              s_nxt.kw_len = 4'h1;
              s_nxt.st = scpi_pkg::ST_KEY;
            end else if (kw_chr) begin
              s_nxt.kw = {s_r.kw[`KW_BITS-9:0], ch};
              s_nxt.kw_len = 4'h1;
              s_nxt.st = scpi_pkg::ST_KEY;
            end else begin
              err = 1'b1;
            end
          end
          scpi_pkg::ST_KEY: begin
            if (ch == `CHAR_COLON) begin
              if (s_r.kw_len == 4'h0 || s_r.common || !hit) begin
                err = 1'b1;
              end else begin
                s_nxt.cur_node = hit_node;
                s_nxt.kw = '0;
                s_nxt.kw_len = 4'h0;
              end
            end else if (ch == `CHAR_QUERY || ch == `CHAR_SPACE) begin
              if (s_r.kw_len == 4'h0 || (!s_r.common && !hit)) begin
                err = 1'b1;
              end else begin
                s_nxt.last_node = s_r.common ? `ROOT_NODE : hit_node;
                s_nxt.last_parent = hit_parent;
                s_nxt.query = (ch == `CHAR_QUERY);
                s_nxt.st = (ch == `CHAR_QUERY) ?
                  scpi_pkg::ST_QUERY : scpi_pkg::ST_DATA;
              end
            end else if (kw_chr && s_r.kw_len != 4'(`KW_CHARS)) begin
              s_nxt.kw = {s_r.kw[`KW_BITS-9:0], ch};
              s_nxt.kw_len = s_r.kw_len + 4'h1;
            end else begin
              err = 1'b1;
            end
          end
          scpi_pkg::ST_QUERY: begin
            if (ch == `CHAR_SPACE) begin
              s_nxt.st = scpi_pkg::ST_DATA;
            end else begin
              err = 1'b1;
            end
          end
          scpi_pkg::ST_DATA: begin
            // A second leading space or an overlong value is refused
            if ((ch == `CHAR_SPACE && s_r.dat_len == '0) ||
                s_r.dat_len == DLW'(DATA_MAX)) begin
              err = 1'b1;
            end else begin
              s_nxt.dat = {s_r.dat[DATA_MAX*8-9:0], in_char};
              s_nxt.dat_len = s_r.dat_len + DLW'(1);
            end
          end
          scpi_pkg::ST_SKIP: begin
          end
          default: begin
            err = 1'b1;
          end
        endcase
      end
    end

    if (close_unit) begin
      case (s_r.st)
        scpi_pkg::ST_KEY: begin
          unit_ok = s_r.kw_len != 4'h0 && (s_r.common || hit);
          next_level = s_r.common ? s_r.unit_base : hit_parent;
        end
        scpi_pkg::ST_QUERY, scpi_pkg::ST_DATA: begin
          unit_ok = !(s_r.st == scpi_pkg::ST_DATA && s_r.dat_len == '0);
          next_level = s_r.common ? s_r.unit_base : s_r.last_parent;
        end
        default: begin
          unit_ok = 1'b0;
        end
      endcase
      if (unit_ok) begin
        s_nxt.unit_valid_r = 1'b1;
        s_nxt.unit_node_r = (s_r.st == scpi_pkg::ST_KEY) ?
          (s_r.common ? `ROOT_NODE : hit_node) : s_r.last_node;
        s_nxt.unit_query_r = s_r.query;
        s_nxt.unit_common_r = s_r.common;
        s_nxt.unit_word_r = s_r.kw;
        s_nxt.unit_data_r = s_r.dat;
        s_nxt.unit_data_len_r = s_r.dat_len;
      end else if (s_r.st != scpi_pkg::ST_START &&
                   s_r.st != scpi_pkg::ST_SKIP) begin
        err = 1'b1;
        next_level = s_r.unit_base;
      end else if (s_r.st == scpi_pkg::ST_START && !term) begin
        err = 1'b1; // Empty unit between semicolons
      end
      s_nxt.st = scpi_pkg::ST_START;
      s_nxt.kw = '0;
      s_nxt.kw_len = 4'h0;
      s_nxt.common = 1'b0;
      s_nxt.query = 1'b0;
      s_nxt.dat = '0;
      s_nxt.dat_len = '0;
      s_nxt.cur_node = next_level;
      s_nxt.unit_base = next_level;
      if (term) begin
        s_nxt.cur_node = `ROOT_NODE;
        s_nxt.unit_base = `ROOT_NODE;
        s_nxt.msg_done_r = 1'b1;
      end
    end

    // A faulty unit is dropped up to its separator
    if (err) begin
      s_nxt.syntax_err_r = 1'b1;
      s_nxt.unit_valid_r = 1'b0;
      if (!close_unit) begin
        s_nxt.st = scpi_pkg::ST_SKIP;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.in_ready_r <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready = s_r.in_ready_r;
  assign unit_valid = s_r.unit_valid_r;
  assign unit_node = s_r.unit_node_r;
  assign unit_query = s_r.unit_query_r;
  assign unit_common = s_r.unit_common_r;
  assign unit_word = s_r.unit_word_r;
  assign unit_data = s_r.unit_data_r;
  assign unit_data_len = s_r.unit_data_len_r;
  assign syntax_err = s_r.syntax_err_r;
  assign msg_done = s_r.msg_done_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence seq_key_delim;
    take && s_r.st == scpi_pkg::ST_KEY && !s_r.common && s_r.kw_len != 4'h0;
  endsequence

  sequence seq_end_close;
    !in_ready ##1 (in_ready && msg_done);
  endsequence

  // Length comes in as an argument so the check sees the sampled value
  function automatic logic kw_len_room(input logic [3:0] len);
    return len != 4'(`KW_CHARS);
  endfunction

  a_term_root: assert property (take && is_term_chr && !s_r.cr_seen
    |=> s_r.cur_node == `ROOT_NODE && msg_done)
    else $error("terminator did not return to root");

  a_root_spec: assert property (take && s_r.st == scpi_pkg::ST_START &&
    in_char == `CHAR_COLON |=> s_r.cur_node == `ROOT_NODE)
    else $error("leading colon did not reset to root");

  a_sep_deeper: assert property (seq_key_delim ##0
    (in_char == `CHAR_COLON && hit)
    |=> s_r.cur_node == $past(hit_node) && s_r.kw_len == 4'h0)
    else $error("colon did not descend one level");

  a_query_mark: assert property (seq_key_delim ##0
    (in_char == `CHAR_QUERY && hit)
    |=> s_r.st == scpi_pkg::ST_QUERY && s_r.query)
    else $error("query mark not recorded");

  a_bad_keyword: assert property (seq_key_delim ##0 !hit ##0
    (in_char == `CHAR_COLON || in_char == `CHAR_SEMI)
    |=> syntax_err && !unit_valid)
    else $error("unknown keyword not flagged");

  a_err_no_exec: assert property (syntax_err |-> !unit_valid)
    else $error("faulty unit delivered");

  a_case_fold: assert property (take && s_r.st == scpi_pkg::ST_KEY &&
    in_char >= `CHAR_LOW_LO && in_char <= `CHAR_LOW_HI &&
    kw_len_room(s_r.kw_len)
    |=> s_r.kw[7:0] == ($past(in_char) & ~`CASE_BIT))
    else $error("lower case not folded");

  a_sibling: assert property (seq_key_delim ##0 hit ##0
    in_char == `CHAR_SEMI
    |=> unit_valid && s_r.cur_node == $past(hit_parent))
    else $error("next unit not resolved beside previous");

  a_common_cmd: assert property (take && s_r.st == scpi_pkg::ST_START &&
    in_char == `CHAR_STAR |=> s_r.common)
    else $error("asterisk not taken as common command");

  a_data_grow: assert property (take && s_r.st == scpi_pkg::ST_DATA &&
    !is_term_chr && in_char != `CHAR_SEMI && in_char != `CHAR_SPACE &&
    s_r.dat_len != DLW'(DATA_MAX)
    |=> s_r.dat_len == $past(s_r.dat_len) + DLW'(1))
    else $error("data character not buffered");

  a_end_close: assert property (take && in_end && !is_term_chr
    |=> seq_end_close)
    else $error("bus end did not close the message");

endmodule

// ### verilog/scpi_pkg.sv
`include "scpi_cfg.svh"

package scpi_pkg;

  typedef enum logic [2:0] {
    ST_START,
    ST_KEY,
    ST_QUERY,
    ST_DATA,
    ST_SKIP
  } parse_state_type;

  // One tree node: long spelling right-aligned, both lengths, parent
  typedef struct packed {
    logic [`KW_BITS-1:0] name;
    logic [3:0] len;
    logic [3:0] slen;
    logic [`NODE_W-1:0] parent;
    logic opt;
  } kw_entry_type;

endpackage
